//--- rtl/ppws_pkg.sv
// Package: register map, field positions and timing for the parallel port
package ppws_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_IN0 = 8'h10;
  localparam logic [7:0] ADDR_OUT0 = 8'h20;
  // Mode register fields
  localparam int HOLD_LSB = 0;
  localparam int STROBE_LSB = 2;
  localparam int PRE_LSB = 6;
  localparam int CS1_BIT = 8;
  localparam int INC_BIT = 9;
  localparam int DEC_BIT = 10;
  localparam int CS1_ADDR_BIT = 14;
  localparam logic [31:0] MODE_MASK = 32'h0000_07FF;
  // Status register fields
  localparam int ALL_FULL_BIT = 15;
  localparam int OVF_BIT = 14;
  localparam int IN_FULL_LSB = 8;
  localparam int ALL_EMPTY_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam int OUT_EMPTY_LSB = 0;
  localparam logic [31:0] EVENT_MASK = 32'h0000_4040;
  localparam int NUM_SLOTS = 4;
  // Strobe cycle phases
  typedef enum logic [1:0] {PPWS_IDLE, PPWS_PRE, PPWS_STROBE, PPWS_HOLD}
    ppws_phase_t;
endpackage

//--- rtl/ppws_top.sv
// Parallel slave port: wait-state timing and slave buffer status
`timescale 1ns/1ps
`default_nettype none
module ppws_top (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host side pins (asynchronous)
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic [1:0] host_addr,
  input wire logic [7:0] host_din,
  output logic [7:0] host_dout,
  output logic [7:0] host_dout_oe,
  output logic host_strobe,
  output logic [15:0] host_addr_out,
  // Interrupt
  output logic irq
);
  // Pin synchronisers: first stage read only by the second
  logic [11:0] sync1, sync2, sync3;
  logic [11:0] next_sync1;
  always_comb begin
    next_sync1 = {host_cs, host_wr, host_addr, host_din};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 12'h000;
      sync2 <= 12'h000;
      sync3 <= 12'h000;
    end else begin
      sync1 <= next_sync1;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  logic cs_s, wr_s, cs_d;
  logic [1:0] sel_s;
  logic [7:0] din_s;
  assign cs_s = sync2[11];
  assign wr_s = sync2[10];
  assign sel_s = sync2[9:8];
  assign din_s = sync2[7:0];
  assign cs_d = sync3[11];

  // Registers
  logic [31:0] mode, mask;
  logic [7:0] in_buf [ppws_pkg::NUM_SLOTS];
  logic [7:0] out_buf [ppws_pkg::NUM_SLOTS];
  logic [3:0] in_full, out_empty;
  logic ovf, unf;
  logic [31:0] next_mode, next_mask;
  logic [7:0] next_in_buf [ppws_pkg::NUM_SLOTS];
  logic [7:0] next_out_buf [ppws_pkg::NUM_SLOTS];
  logic [3:0] next_in_full, next_out_empty;
  logic next_ovf, next_unf;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;
  logic [7:0] next_host_dout;

  // Field extraction
  logic [3:0] strobe_ws;
  logic [1:0] hold_ws, pre_ws;
  assign strobe_ws = mode[ppws_pkg::STROBE_LSB +: 4];
  assign hold_ws = mode[ppws_pkg::HOLD_LSB +: 2];
  assign pre_ws = mode[ppws_pkg::PRE_LSB +: 2];

  function automatic logic [31:0] status_word(input logic [3:0] f,
      input logic [3:0] e, input logic o, input logic u);
    logic [31:0] s;
    s = 32'h0000_0000;
    s[ppws_pkg::ALL_FULL_BIT] = &f;
    s[ppws_pkg::OVF_BIT] = o;
    s[ppws_pkg::IN_FULL_LSB +: 4] = f;
    s[ppws_pkg::ALL_EMPTY_BIT] = &e;
    s[ppws_pkg::UNF_BIT] = u;
    s[ppws_pkg::OUT_EMPTY_LSB +: 4] = e;
    return s;
  endfunction

  // Address stepping; with the CS1 mode bit set, the chip-select bit (address bit 14) never moves with it
  function automatic logic [15:0] step_addr(input logic [15:0] a,
      input logic [31:0] md);
    logic [15:0] n;
    n = a;
    if (md[ppws_pkg::INC_BIT]) begin
      n = a + 16'h0001;
    end else if (md[ppws_pkg::DEC_BIT]) begin
      n = a - 16'h0001;
    end
    if (md[ppws_pkg::CS1_BIT]) begin
      n[ppws_pkg::CS1_ADDR_BIT] = a[ppws_pkg::CS1_ADDR_BIT];
    end
    return n;
  endfunction

  // Host strobe sequencer state
  ppws_pkg::ppws_phase_t phase, next_phase;
  logic [3:0] cnt, next_cnt;
  logic cyc_wr, next_cyc_wr;
  logic [15:0] addr_q, next_addr_q;
  logic host_start;
  assign host_start = cs_s && !cs_d;

  // Strobe timing sequencer, one access per host select edge
  always_comb begin
    next_phase = phase;
    next_cnt = cnt;
    next_cyc_wr = cyc_wr;
    next_addr_q = addr_q;
    unique case (phase)
      ppws_pkg::PPWS_IDLE: begin
        if (host_start) begin
          next_cyc_wr = wr_s;
          next_phase = ppws_pkg::PPWS_PRE;
          next_cnt = (strobe_ws == 4'h0) ? 4'h0 : {2'b00, pre_ws};
        end
      end
      ppws_pkg::PPWS_PRE: begin
        if (cnt == 4'h0) begin
          next_phase = ppws_pkg::PPWS_STROBE;
          next_cnt = strobe_ws;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      ppws_pkg::PPWS_STROBE: begin
        if (cnt == 4'h0) begin
          if (strobe_ws == 4'h0 && cyc_wr) begin
            next_phase = ppws_pkg::PPWS_HOLD;
            next_cnt = 4'h0;
          end else if (cyc_wr) begin
            next_phase = ppws_pkg::PPWS_HOLD;
            next_cnt = {2'b00, hold_ws};
          end else if (strobe_ws == 4'h0 || hold_ws == 2'b00) begin
            // Read with no hold ends here, so it steps here too
            next_phase = ppws_pkg::PPWS_IDLE;
            next_addr_q = step_addr(addr_q, mode);
          end else begin
            next_phase = ppws_pkg::PPWS_HOLD;
            next_cnt = {2'b00, hold_ws} - 4'h1;
          end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      ppws_pkg::PPWS_HOLD: begin
        if (cnt == 4'h0) begin
          next_phase = ppws_pkg::PPWS_IDLE;
          next_addr_q = step_addr(addr_q, mode);
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= ppws_pkg::PPWS_IDLE;
      cnt <= 4'h0;
      cyc_wr <= 1'b0;
      addr_q <= 16'h0000;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      cyc_wr <= next_cyc_wr;
      addr_q <= next_addr_q;
    end
  end

  // APB decode; host access acts at start of its cycle
  logic apb_setup, apb_wr, apb_rd;
  logic [1:0] slot;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign slot = paddr[3:2];

  always_comb begin
    next_mode = mode;
    next_mask = mask;
    next_in_full = in_full;
    next_out_empty = out_empty;
    next_ovf = ovf;
    next_unf = unf;
    next_host_dout = host_dout;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    for (int i = 0; i < ppws_pkg::NUM_SLOTS; i++) begin
      next_in_buf[i] = in_buf[i];
      next_out_buf[i] = out_buf[i];
    end
    // Read data and refusal settle in setup, so they stand with pready
    if (apb_setup) begin
      unique case (paddr & 8'hF0)
        8'h00: begin
          if (paddr == ppws_pkg::ADDR_MODE) begin
            next_prdata = mode;
          end else if (paddr == ppws_pkg::ADDR_STAT) begin
            next_prdata = status_word(in_full, out_empty, ovf, unf);
          end else if (paddr == ppws_pkg::ADDR_MASK) begin
            next_prdata = mask;
          end else begin
            next_pslverr = 1'b1;
          end
        end
        ppws_pkg::ADDR_IN0: begin
          next_prdata = {24'h000000, in_buf[slot]};
          next_pslverr = pwrite;
        end
        ppws_pkg::ADDR_OUT0: next_pslverr = !pwrite;
        default: next_pslverr = 1'b1;
      endcase
      if (pwrite) begin
        next_prdata = 32'h0000_0000;
      end
    end
    // CPU side effects at the access edge; hardware sets below win
    if (apb_wr) begin
      if (paddr == ppws_pkg::ADDR_MODE) begin
        next_mode = pwdata & ppws_pkg::MODE_MASK;
      end else if (paddr == ppws_pkg::ADDR_STAT) begin
        if (pwdata[ppws_pkg::OVF_BIT]) next_ovf = 1'b0;
        if (pwdata[ppws_pkg::UNF_BIT]) next_unf = 1'b0;
      end else if (paddr == ppws_pkg::ADDR_MASK) begin
        next_mask = pwdata & ppws_pkg::EVENT_MASK;
      end else if ((paddr & 8'hF0) == ppws_pkg::ADDR_OUT0) begin
        next_out_buf[slot] = pwdata[7:0];
        next_out_empty[slot] = 1'b0;
      end
    end else if (apb_rd && (paddr & 8'hF0) == ppws_pkg::ADDR_IN0) begin
      next_in_full[slot] = 1'b0;
    end
    // Host side access, caught on the select edge
    if (phase == ppws_pkg::PPWS_IDLE && host_start) begin
      if (wr_s) begin
        if (in_full[sel_s]) begin
          next_ovf = 1'b1;
        end else begin
          next_in_buf[sel_s] = din_s;
          next_in_full[sel_s] = 1'b1;
        end
      end else begin
        next_host_dout = out_buf[sel_s];
        if (out_empty[sel_s]) begin
          next_unf = 1'b1;
        end else begin
          next_out_empty[sel_s] = 1'b1;
        end
      end
    end
    next_pready = psel && !penable;
    next_irq = |(status_word(next_in_full, next_out_empty, next_ovf,
      next_unf) & mask);
  end

  // Register update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= 32'h0000_0000;
      mask <= 32'h0000_0000;
      in_full <= 4'h0;
      out_empty <= 4'hF;
      ovf <= 1'b0;
      unf <= 1'b0;
      host_dout <= 8'h00;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
      irq <= 1'b0;
      for (int i = 0; i < ppws_pkg::NUM_SLOTS; i++) begin
        in_buf[i] <= 8'h00;
        out_buf[i] <= 8'h00;
      end
    end else begin
      mode <= next_mode;
      mask <= next_mask;
      in_full <= next_in_full;
      out_empty <= next_out_empty;
      ovf <= next_ovf;
      unf <= next_unf;
      host_dout <= next_host_dout;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= next_pready;
      irq <= next_irq;
      for (int i = 0; i < ppws_pkg::NUM_SLOTS; i++) begin
        in_buf[i] <= next_in_buf[i];
        out_buf[i] <= next_out_buf[i];
      end
    end
  end

  // Pin outputs registered for clean edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_strobe <= 1'b0;
      host_dout_oe <= 8'h00;
      host_addr_out <= 16'h0000;
    end else begin
      host_strobe <= (next_phase == ppws_pkg::PPWS_STROBE);
      host_dout_oe <= (next_phase != ppws_pkg::PPWS_IDLE && !next_cyc_wr)
        ? 8'hFF : 8'h00;
      host_addr_out <= next_addr_q;
    end
  end
endmodule
`default_nettype wire

//--- tb/ppws_properties.sv
// Assertion checker for the parallel slave port
`timescale 1ns/1ps
`default_nettype none
module ppws_checker (
  // APB side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Host side
  input wire logic host_strobe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Status read answers only
  wire logic st = pready && !pwrite && paddr == ppws_pkg::ADDR_STAT;
  // Bus answer timing and refusal
  AST_PREADY_ACCESS: assert property (psel && !penable |=> pready)
    else $error("no answer in the access cycle");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_UNMAPPED: assert property (pready && paddr == 8'hFC |-> pslverr)
    else $error("unmapped address not refused");
  AST_MAPPED: assert property (st |-> !pslverr)
    else $error("status read refused");
  // Status bit layout
  AST_STAT_ZERO: assert property (st |-> (prdata & 32'hFFFF_3030) == 0)
    else $error("unused status bits not zero");
  AST_ALL_FULL: assert property (st |-> prdata[15] == &prdata[11:8])
    else $error("all full flag disagrees with slots");
  AST_ALL_EMPTY: assert property (st |-> prdata[7] == &prdata[3:0])
    else $error("all empty flag disagrees with slots");
  // Widest strobe is sixteen periods
  AST_STROBE_LEN: assert property ($rose(host_strobe) |-> ##[1:16] !host_strobe)
    else $error("strobe longer than sixteen periods");
endmodule
bind ppws_top ppws_checker i_ppws_checker (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .host_strobe);
`default_nettype wire

//--- tb/ppws_host_model.sv
// Behavioural external host on the parallel slave pins
`timescale 1ns/1ps
`default_nettype none
module ppws_host_model (
  // Port timing seen by the host
  input wire logic pclk,
  input wire logic host_strobe,
  // Host pins
  output logic host_cs,
  output logic host_wr,
  output logic [1:0] host_addr,
  output logic [7:0] host_din,
  // Port never answered
  output logic hang
);
  // Idle pins at time zero
  initial begin
    {host_cs, host_wr, host_addr, hang} = '0;
    host_din = 8'hA5;
  end
  // One byte per select; bench checks flags first
  task automatic access(input logic w, input logic [1:0] a,
    input logic [7:0] d);
    int n;
    @(posedge pclk);
    host_cs <= 1'b1;
    host_wr <= w;
    host_addr <= a;
    host_din <= d;
    n = 0;
    while (host_strobe !== 1'b1 && n < 64) begin
      @(posedge pclk);
      n++;
    end
    while (host_strobe !== 1'b0 && n < 64) begin
      @(posedge pclk);
      n++;
    end
    // Cover the longest hold before release
    repeat (5) @(posedge pclk);
    host_cs <= 1'b0;
    host_din <= ~d;
    repeat (4) @(posedge pclk);
    if (n >= 64) hang = 1'b1;
  endtask
endmodule
`default_nettype wire

//--- tb/test_parallel_port_wait_and_slave_status.sv
// Self-checking bench for the parallel slave port
`timescale 1ns/1ps
`default_nettype none
module test_parallel_port_wait_and_slave_status;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic host_cs, host_wr, host_strobe, hang, er;
  logic [15:0] host_addr_out, a0;
  logic [7:0] host_dout_oe;
  logic [1:0] host_addr;
  logic [7:0] paddr, host_din, host_dout, b;
  logic [31:0] pwdata, prdata, rd, m;
  logic [7:0] inb [4];
  int miscompares, compares, slen, s, olen, hlen;
  ppws_top i_ppws_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .host_cs, .host_wr, .host_addr,
    .host_din, .host_dout, .host_dout_oe, .host_strobe,
    .host_addr_out, .irq);
  ppws_host_model i_ppws_host_model (.pclk, .host_strobe, .host_cs,
    .host_wr, .host_addr, .host_din, .hang);
  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Strobe, driven-bus and hold widths in clock periods
  // Hold counts only under select, so a reset in host() never races it
  always @(posedge pclk) begin
    if (host_strobe === 1'b1) slen <= slen + 1;
    if (host_dout_oe === 8'hFF) olen <= olen + 1;
    if (host_cs === 1'b1 && host_strobe === 1'b0 && slen > 0 &&
        host_addr_out === a0) hlen <= hlen + 1;
  end
  // Compare and closing report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Expected hold and driven-bus periods, from the mode word
  function automatic int hold_exp(input logic [31:0] md, input logic w);
    int h;
    h = md[ppws_pkg::HOLD_LSB +: 2];
    if (md[ppws_pkg::STROBE_LSB +: 4] == 4'h0) h = w ? 1 : 0;
    else if (w) h = h + 1;
    return h;
  endfunction
  function automatic int drive_exp(input logic [31:0] md);
    int p;
    int t;
    t = md[ppws_pkg::STROBE_LSB +: 4];
    p = (t == 0) ? 1 : md[ppws_pkg::PRE_LSB +: 2] + 1;
    return p + t + 1 + hold_exp(md, 1'b0);
  endfunction
  // APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      end_of_test();
    end
  endtask
  // Host access with strobe width count
  task automatic host(input logic w, input logic [1:0] a,
    input logic [7:0] d);
    slen = 0;
    olen = 0;
    hlen = 0;
    a0 = host_addr_out;
    i_ppws_host_model.access(w, a, d);
    if (hang) begin
      miscompares++;
      end_of_test();
    end
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h1AFC));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    slen = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ppws_pkg::ADDR_MODE, 0);
    chk(rd, 32'h0);
    apb(0, ppws_pkg::ADDR_MASK, 0);
    chk(rd, 32'h0);
    apb(0, ppws_pkg::ADDR_STAT, 0);
    chk(rd, 32'h0000_008F);
    apb(0, 8'hFC, 0);
    chk({31'h0, er}, 32'h1);
    $display("test reset values done");
    // Strobe field ends and random widths; zero ignores pre and hold
    for (int i = 0; i < 4; i++) begin
      s = (i == 0) ? 0 : (i == 1) ? 15 : $urandom_range(14, 1);
      // Up-stepping on, so the end of the hold shows on the address pins
      m = ($urandom & 32'h0000_05C3) | 32'h0000_0200 | (s << 2);
      apb(1, ppws_pkg::ADDR_MODE, m);
      apb(0, ppws_pkg::ADDR_MODE, 0);
      chk(rd, m);
      inb[i] = 8'($urandom);
      host(1, i[1:0], inb[i]);
      chk(slen, s + 1);
      chk(hlen, hold_exp(m, 1'b1));
    end
    apb(0, ppws_pkg::ADDR_STAT, 0);
    chk(rd, 32'h0000_8F8F);
    $display("test strobe and hold timing done");
    host(1, 2'd0, 8'h3C);
    apb(1, ppws_pkg::ADDR_MASK, ppws_pkg::EVENT_MASK);
    apb(0, ppws_pkg::ADDR_STAT, 0);
    chk(rd, 32'h0000_CF8F);
    chk({31'h0, irq}, 32'h1);
    apb(0, ppws_pkg::ADDR_IN0 + 8'h04, 0);
    chk({24'h0, rd[7:0]}, {24'h0, inb[1]});
    apb(1, ppws_pkg::ADDR_STAT, 32'hFFFF_FFFF);
    apb(0, ppws_pkg::ADDR_STAT, 0);
    chk(rd, 32'h0000_0D8F);
    chk({31'h0, irq}, 32'h0);
    // Output slot loaded by the CPU, then read by the host
    b = 8'($urandom);
    apb(1, ppws_pkg::ADDR_OUT0 + 8'h04, {24'h0, b});
    apb(0, ppws_pkg::ADDR_STAT, 0);
    chk(rd, 32'h0000_0D0D);
    host(0, 2'd1, 8'h00);
    chk({24'h0, host_dout}, {24'h0, b});
    chk(slen, s + 1);
    chk(hlen, hold_exp(m, 1'b0));
    chk(olen, drive_exp(m));
    host(0, 2'd2, 8'h00);
    apb(0, ppws_pkg::ADDR_STAT, 0);
    chk(rd, 32'h0000_0DCF);
    chk({31'h0, irq}, 32'h1);
    $display("test buffer flags done");
    // Second reset mid-run, then a down-step across the chip-select bit
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ppws_pkg::ADDR_STAT, 0);
    chk(rd, 32'h0000_008F);
    apb(1, ppws_pkg::ADDR_MODE, (32'h1 << ppws_pkg::DEC_BIT) |
      (32'h1 << ppws_pkg::CS1_BIT));
    host(0, 2'd3, 8'h00);
    chk({16'h0, host_addr_out}, 32'h0000_BFFF);
    $display("test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
